//--- core/sacq_pkg.sv
// constants, state record and register map of the scanned acquisition sequencer
package sacq_pkg;
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned TB1_HZ   = 1_000_000;
  localparam int unsigned PRE_DIV  = CLK_HZ / TB1_HZ;
  localparam logic [5:0]  PRE_LAST = 6'(PRE_DIV - 1);
  localparam int          DEC_N    = 4;
  localparam logic [3:0]  DEC_LAST = 4'h9;
  localparam int          TB_N     = 6;
  localparam logic [2:0]  TB_EXT   = 3'h5;

  localparam logic [15:0] MODE_1MHZ   = 16'h8b25;
  localparam logic [15:0] MODE_100KHZ = 16'h8c25;
  localparam logic [15:0] MODE_10KHZ  = 16'h8d25;
  localparam logic [15:0] MODE_1KHZ   = 16'h8e25;
  localparam logic [15:0] MODE_100HZ  = 16'h8f25;
  localparam logic [15:0] MODE_SRC5   = 16'h8525;
  localparam logic [15:0] MODE_RST    = 16'h8b25;
  localparam logic [15:0] LOAD_RST    = 16'h0002;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] TRIG_VALUE  = 16'h0000;

  localparam int          FIFO_AW   = 9;
  localparam int          FIFO_N    = 512;
  localparam logic [9:0]  FIFO_FULL = 10'h200;
  localparam int          SMEM_AW   = 4;
  localparam int          SMEM_N    = 16;
  localparam int          END_BIT   = 8;
  localparam int          CHAN_W    = 8;

  localparam logic [7:0] OFS_CMD1      = 8'h00;
  localparam logic [7:0] OFS_CMD2      = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_RESULT    = 8'h0c;
  localparam logic [7:0] OFS_START     = 8'h10;
  localparam logic [7:0] OFS_CLEAR     = 8'h14;
  localparam logic [7:0] OFS_POS       = 8'h18;
  localparam logic [7:0] OFS_ENTRY     = 8'h1c;
  localparam logic [7:0] OFS_MODE      = 8'h20;
  localparam logic [7:0] OFS_SI_LOAD   = 8'h24;
  localparam logic [7:0] OFS_SC_LOAD   = 8'h28;
  localparam logic [7:0] OFS_SCAN_LOAD = 8'h2c;

  localparam int ACQ_EN_BIT   = 0;
  localparam int SCAN_EN_BIT  = 1;
  localparam int REPEAT_BIT   = 2;
  localparam int SCAN_INT_BIT = 0;
  localparam int AVAIL_BIT    = 13;
  localparam int OVF_BIT      = 12;
  localparam int OVR_BIT      = 11;
  localparam int ACTIVE_BIT   = 10;

  localparam int P_TRIG = 0;
  localparam int P_TIMER_OUTPUT_ONE = 1;
  localparam int P_SRC5 = 2;
  localparam int P_BUSY = 3;
  localparam int P_DONE = 4;
  localparam int P_DATA = 5;
  localparam int PIN_W  = 21;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SCAN_WAIT} sacq_state_t;

  typedef struct packed {
    logic [PIN_W-1:0]                 pin_meta;
    logic [PIN_W-1:0]                 pin_sync;
    logic [PIN_W-1:0]                 pin_prev;
    logic                             awready;
    logic                             wready;
    logic                             aw_full;
    logic [7:0]                       aw_addr;
    logic                             w_full;
    logic [31:0]                      w_data;
    logic [3:0]                       w_strb;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             arready;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
    logic [2:0]                       cmd1;
    logic                             cmd2;
    logic [15:0]                      mode;
    logic [15:0]                      si_load;
    logic [15:0]                      sc_load;
    logic [15:0]                      scan_load;
    logic [15:0]                      si_cnt;
    logic [15:0]                      samp_cnt;
    logic [15:0]                      scan_cnt;
    logic                             scan_tc;
    logic [5:0]                       pre_cnt;
    logic [DEC_N-1:0][3:0]            dec_cnt;
    logic [SMEM_AW-1:0]               pos;
    logic [SMEM_N-1:0][END_BIT:0]     smem;
    logic [CHAN_W-1:0]                chan;
    logic [FIFO_AW:0]                 fcount;
    logic [FIFO_AW-1:0]               wr_ptr;
    logic [FIFO_AW-1:0]               rd_ptr;
    logic                             ovf;
    logic                             ovr;
    logic                             conv_start;
    logic                             active;
    sacq_state_t                      state;
  } sacq_st_t;
endpackage : sacq_pkg

//--- core/sacq_top.sv
// scanned acquisition sequencer with axi4-lite register slave and result fifo
// Functional notes
// RL1 - acquisition arms with acquisition enable; scanning needs scan enable too
// RL2 - writing zero to the start register triggers the armed acquisition
// RL3 - falling edge on external trigger pin triggers the armed acquisition
// RL4 - one conversion start per sample interval until the sample count ends
// RL5 - status bit 13 shows a result is waiting; read fifo only then
// RL6 - overflow or overrun halts acquisition; both shown in status
// RL7 - result arriving with 512 unread sets overflow and is dropped
// RL8 - conversion start while converter busy sets overrun
// RL9 - any write to the clear register clears overflow and overrun
// RL10 - scan enable clear holds one channel; set follows scan memory
// RL11 - scan interval enabled: each pass waits for the scan counter terminal
// RL12 - first conversion uses first entry, then one entry per conversion
// RL13 - after the entry marked sequence end the scan wraps to entry zero
// RL14 - repeat select set advances on timer output one low pulse only
// RL15 - software writes position then entry for each scan memory slot
// RL16 - sample interval spans 2 to 65536 ticks of the chosen timebase
// RL17 - mode code picks timebase; 8525 counts external source five edges
// RL18 - software programs the interval counter with 16-bit writes in order
// RL19 - load values 2 to ffff direct; zero means 65536
// RL20 - software keeps the scan interval long enough for a full pass
// RL21 - scan interval at least sample interval times entry count
// RL22 - sample counter drops per conversion; acquisition stops at zero
// RL23 - fifo returns oldest first; available flag tracks non-empty
module sacq_top
  import sacq_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  input  wire logic                i_awvalid,
  input  wire logic [7:0]          i_awaddr,
  output logic                     o_awready,
  input  wire logic                i_wvalid,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  output logic                     o_wready,
  output logic                     o_bvalid,
  output logic [1:0]               o_bresp,
  input  wire logic                i_bready,
  input  wire logic                i_arvalid,
  input  wire logic [7:0]          i_araddr,
  output logic                     o_arready,
  output logic                     o_rvalid,
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  input  wire logic                i_rready,
  input  wire logic                i_ext_acquisition_trigger_n,
  input  wire logic                i_timer_output_one_n,
  input  wire logic                i_external_source_five,
  input  wire logic                i_conv_busy,
  input  wire logic                i_conv_done,
  input  wire logic [15:0]         i_conv_data,
  output logic                     o_conv_start,
  output logic [CHAN_W-1:0]        o_chan_gain,
  output logic                     o_acq_active
);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // timebase index from the interval mode code
  function automatic logic [2:0] tb_index(input logic [15:0] mode);
    unique case (mode)
      MODE_100KHZ: tb_index = 3'h1;
      MODE_10KHZ:  tb_index = 3'h2;
      MODE_1KHZ:   tb_index = 3'h3;
      MODE_100HZ:  tb_index = 3'h4;
      MODE_SRC5:   tb_index = TB_EXT;
      default:     tb_index = 3'h0;
    endcase
  endfunction : tb_index

  logic                rst_meta;
  logic                rst_n;
  sacq_st_t            r;
  sacq_st_t            n;
  logic [15:0]         fifo_mem [FIFO_N];
  logic [15:0]         fifo_rd;
  logic                push;
  logic [FIFO_AW-1:0]  push_addr;
  logic [15:0]         push_data;
  logic [TB_N-1:0]     tb;
  logic                tick;
  logic                trig;
  logic                sw_trig;
  logic                clr;
  logic                fire;
  logic                adv;
  logic                ovf_set;
  logic                ovr_set;
  logic                wr_do;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign fifo_rd = fifo_mem[r.rd_ptr];

  always_comb begin
    n         = r;
    push      = 1'b0;
    push_addr = r.wr_ptr;
    push_data = r.pin_sync[P_DATA +: 16];
    sw_trig   = 1'b0;
    clr       = 1'b0;
    fire      = 1'b0;
    adv       = 1'b0;
    ovf_set   = 1'b0;
    ovr_set   = 1'b0;
    n.conv_start = 1'b0;
    n.pin_meta = {i_conv_data, i_conv_done, i_conv_busy, i_external_source_five,
                  i_timer_output_one_n, i_ext_acquisition_trigger_n};
    n.pin_sync = r.pin_meta;
    n.pin_prev = r.pin_sync;
    // RL3 hardware trigger edge
    trig = r.pin_prev[P_TRIG] & ~r.pin_sync[P_TRIG];

    // RL16 timebase chain
    tb = '0;
    tb[0] = (r.pre_cnt == PRE_LAST);
    n.pre_cnt = tb[0] ? 6'h00 : r.pre_cnt + 6'h01;
    for (int k = 0; k < DEC_N; k++) begin
      tb[k+1] = tb[k] && (r.dec_cnt[k] == DEC_LAST);
      if (tb[k]) begin
        n.dec_cnt[k] = (r.dec_cnt[k] == DEC_LAST) ? 4'h0 : r.dec_cnt[k] + 4'h1;
      end
    end
    // RL17 external source edges
    tb[TB_EXT] = r.pin_sync[P_SRC5] & ~r.pin_prev[P_SRC5];
    tick = tb[tb_index(r.mode)];

    if (r.awready && i_awvalid) begin
      n.aw_full = 1'b1;
      n.aw_addr = i_awaddr;
    end
    if (r.wready && i_wvalid) begin
      n.w_full = 1'b1;
      n.w_data = i_wdata;
      n.w_strb = i_wstrb;
    end
    if (r.bvalid && i_bready) begin
      n.bvalid = 1'b0;
    end
    wr_do = r.aw_full && r.w_full && !r.bvalid;
    if (wr_do) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      unique case (r.aw_addr)
        OFS_CMD1:      n.cmd1 = r.w_strb[0] ? r.w_data[2:0] : r.cmd1;
        OFS_CMD2:      n.cmd2 = r.w_strb[0] ? r.w_data[SCAN_INT_BIT] : r.cmd2;
        // RL2 software trigger
        OFS_START:     sw_trig = (r.w_data[15:0] == TRIG_VALUE);
        // RL9 clear errors
        OFS_CLEAR:     clr = 1'b1;
        // RL15 scan memory loading
        OFS_POS:       n.pos = r.w_strb[0] ? r.w_data[SMEM_AW-1:0] : r.pos;
        OFS_ENTRY:     n.smem[r.pos] = r.w_data[END_BIT:0];
        // RL18 interval mode
        OFS_MODE:      n.mode = merge16(r.mode, r.w_data, r.w_strb);
        OFS_SI_LOAD:   n.si_load = merge16(r.si_load, r.w_data, r.w_strb);
        OFS_SC_LOAD:   n.sc_load = merge16(r.sc_load, r.w_data, r.w_strb);
        OFS_SCAN_LOAD: n.scan_load = merge16(r.scan_load, r.w_data, r.w_strb);
        default:       n.bresp = RESP_SLVERR;
      endcase
    end

    if (clr) begin
      n.fcount = '0;
      n.wr_ptr = '0;
      n.rd_ptr = '0;
    end
    if (r.rvalid && i_rready) begin
      n.rvalid = 1'b0;
    end
    if (r.arready && i_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      unique case (i_araddr)
        OFS_CMD1:      n.rdata[2:0] = r.cmd1;
        OFS_CMD2:      n.rdata[SCAN_INT_BIT] = r.cmd2;
        OFS_STATUS: begin
          // RL5 result available flag
          n.rdata[AVAIL_BIT]  = (r.fcount != '0);
          n.rdata[OVF_BIT]    = r.ovf;
          n.rdata[OVR_BIT]    = r.ovr;
          n.rdata[ACTIVE_BIT] = r.active;
        end
        // RL23 oldest result first
        OFS_RESULT: begin
          if (r.fcount != '0 && !clr) begin
            n.rdata[15:0] = fifo_rd;
            n.rd_ptr = r.rd_ptr + 9'h001;
            n.fcount = r.fcount - 10'h001;
          end
        end
        OFS_POS:       n.rdata[SMEM_AW-1:0] = r.pos;
        OFS_MODE:      n.rdata[15:0] = r.mode;
        OFS_SI_LOAD:   n.rdata[15:0] = r.si_load;
        OFS_SC_LOAD:   n.rdata[15:0] = r.samp_cnt;
        OFS_SCAN_LOAD: n.rdata[15:0] = r.scan_load;
        OFS_START, OFS_CLEAR, OFS_ENTRY: n.rdata = '0;
        default:       n.rresp = RESP_SLVERR;
      endcase
    end

    // RL7 full fifo drops result
    if (r.pin_sync[P_DONE] && !r.pin_prev[P_DONE]) begin
      if (n.fcount == FIFO_FULL) begin
        ovf_set = 1'b1;
      end else begin
        push      = 1'b1;
        push_addr = n.wr_ptr;
        n.wr_ptr  = n.wr_ptr + 9'h001;
        n.fcount  = n.fcount + 10'h001;
      end
    end

    // RL11 scan interval countdown
    if (r.state != ST_IDLE && tick && !r.scan_tc) begin
      if (r.scan_cnt == CNT_ONE) begin
        n.scan_tc = 1'b1;
      end else begin
        n.scan_cnt = r.scan_cnt - CNT_ONE;
      end
    end

    unique case (r.state)
      ST_IDLE: begin
        // RL1 arming condition
        if ((sw_trig || trig) && r.cmd1[ACQ_EN_BIT] && !r.ovf && !r.ovr) begin
          n.state    = ST_RUN;
          n.si_cnt   = r.si_load;
          n.samp_cnt = r.sc_load;
          n.scan_cnt = r.scan_load;
          n.scan_tc  = 1'b0;
        end
      end
      ST_RUN: begin
        // RL19 zero load wraps to 65536
        if (tick) begin
          if (r.si_cnt == CNT_ONE) begin
            fire     = 1'b1;
            n.si_cnt = r.si_load;
          end else begin
            n.si_cnt = r.si_cnt - CNT_ONE;
          end
        end
      end
      ST_SCAN_WAIT: begin
        if (r.scan_tc) begin
          n.state    = ST_RUN;
          n.si_cnt   = r.si_load;
          n.scan_cnt = r.scan_load;
          n.scan_tc  = 1'b0;
        end
      end
    endcase

    // RL4 conversion start pulse
    if (fire) begin
      n.conv_start = 1'b1;
      // RL8 start while busy
      ovr_set = r.pin_sync[P_BUSY];
      // RL22 sample count ends run
      if (r.samp_cnt == CNT_ONE) begin
        n.state = ST_IDLE;
      end
      n.samp_cnt = r.samp_cnt - CNT_ONE;
    end

    // RL14 advance source select
    adv = (r.state == ST_RUN) && r.cmd1[SCAN_EN_BIT] &&
          (r.cmd1[REPEAT_BIT] ? (r.pin_prev[P_TIMER_OUTPUT_ONE] & ~r.pin_sync[P_TIMER_OUTPUT_ONE]) : fire);
    // RL10 scan follows memory
    if (adv) begin
      // RL13 wrap after sequence end
      if (r.smem[r.pos][END_BIT]) begin
        n.pos = '0;
        if (r.cmd2 && n.state == ST_RUN) begin
          n.state = ST_SCAN_WAIT;
        end
      end else begin
        // RL12 one entry per step
        n.pos = r.pos + 4'h1;
      end
    end

    if (clr) begin
      n.ovf = 1'b0;
      n.ovr = 1'b0;
    end
    if (ovf_set) begin
      n.ovf = 1'b1;
    end
    if (ovr_set) begin
      n.ovr = 1'b1;
    end
    // RL6 errors halt acquisition
    if (n.ovf || n.ovr || !r.cmd1[ACQ_EN_BIT]) begin
      n.state = ST_IDLE;
    end

    n.chan    = r.smem[r.pos][CHAN_W-1:0];
    n.active  = (n.state != ST_IDLE);
    n.awready = ~n.aw_full;
    n.wready  = ~n.w_full;
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      r           <= '0;
      r.pin_meta  <= '1;
      r.pin_sync  <= '1;
      r.pin_prev  <= '1;
      r.mode      <= MODE_RST;
      r.si_load   <= LOAD_RST;
      r.sc_load   <= LOAD_RST;
      r.scan_load <= LOAD_RST;
      r.state     <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      fifo_mem[push_addr] <= push_data;
    end
  end

  assign o_awready    = r.awready;
  assign o_wready     = r.wready;
  assign o_bvalid     = r.bvalid;
  assign o_bresp      = r.bresp;
  assign o_arready    = r.arready;
  assign o_rvalid     = r.rvalid;
  assign o_rdata      = r.rdata;
  assign o_rresp      = r.rresp;
  assign o_conv_start = r.conv_start;
  assign o_chan_gain  = r.chan;
  assign o_acq_active = r.active;

endmodule : sacq_top

//--- dv/sacq_properties.sv
// concurrent checks on the sequencer's top-level ports
module sacq_properties
  import sacq_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        i_rready,
  input wire logic        i_conv_busy,
  input wire logic        o_conv_start,
  input wire logic        o_acq_active
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  chk_start_pulse:
    assert property (o_conv_start |=> !o_conv_start [*3]) else $error("start pulse too long");
  chk_start_armed:
    assert property ($rose(o_conv_start) |-> $past(o_acq_active)) else $error("start while idle");
  // no start in the first four cycles of a run
  chk_first_gap:
    assert property ($rose(o_acq_active) |-> !o_conv_start [*4]) else $error("start too soon");
  chk_overrun_halt:
    assert property (i_conv_busy [*4] ##1 (i_conv_busy && o_conv_start) |-> ##[1:4] !o_acq_active)
      else $error("run kept going after overrun");
  chk_write_resp:
    assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid ##1 o_bvalid)
      else $error("late bvalid");
  chk_w_block:
    assert property (i_wvalid && o_wready |=> !o_wready) else $error("wready stayed high");
  chk_aw_block:
    assert property (i_awvalid && o_awready |=> !o_awready) else $error("awready stayed high");
  chk_b_release:
    assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready) else $error("bad write release");
  chk_read_resp:
    assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready) else $error("late rvalid");
  chk_r_release:
    assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready) else $error("bad read release");
  chk_err_zero:
    assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0) else $error("error read not zero");
endmodule : sacq_properties

//--- dv/sacq_conv_model.sv
// converter front end model answering conversion starts
module sacq_conv_model (
  input  wire logic       i_clock,
  input  wire logic       i_start,
  input  wire logic [7:0] i_chan,
  input  wire logic       i_slow,
  output logic            o_busy,
  output logic            o_done,
  output logic [15:0]     o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int         n = 0;
  logic [7:0] ch;
  initial begin
    o_busy = 0;
    o_done = 0;
    o_data = 16'hffff;
    forever begin
      @(posedge i_clock);
      if (i_start === 1'b1) begin
        ch = i_chan;
        o_busy <= 1;
        repeat (i_slow ? 120 : 10) @(posedge i_clock);
        o_busy <= 0;
        o_data <= {8'ha5 ^ n[7:0], ch};
        n++;
        @(posedge i_clock);
        o_done <= 1;
        repeat (6) @(posedge i_clock);
        o_done <= 0;
        @(posedge i_clock);
        o_data <= ~o_data;
      end
    end
  end
endmodule : sacq_conv_model

//--- dv/sacq_top_tb.sv
// self-checking testbench of the scanned acquisition sequencer
module sacq_top_tb
  import sacq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 0, i_nrst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic        trg_n = 1, t1_n = 1, src5 = 0, slow = 0;
  logic        awr, wrdy, bv, arr, rv, cs, act, busy, done;
  logic [7:0]  awa = 0, ara = 0, cg;
  logic [31:0] wd = 0, rdv, rdat;
  logic [1:0]  br, rresp, rr, wrr;
  logic [15:0] cdata;
  logic [31:0] lfsr = 32'he2b432a7;
  logic [7:0]  ent [3];
  logic [7:0]  chq [$];
  int          tq [$];
  int          mismatches = 0, n_tests = 0, cyc = 0, nk = 0, k0 = 0;

  sacq_top sacq_top_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_awvalid(awv), .i_awaddr(awa), .o_awready(awr),
    .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hf), .o_wready(wrdy), .o_bvalid(bv), .o_bresp(br), .i_bready(bre),
    .i_arvalid(arv), .i_araddr(ara), .o_arready(arr), .o_rvalid(rv), .o_rdata(rdat), .o_rresp(rresp),
    .i_rready(rre), .i_ext_acquisition_trigger_n(trg_n), .i_timer_output_one_n(t1_n),
    .i_external_source_five(src5), .i_conv_busy(busy), .i_conv_done(done), .i_conv_data(cdata),
    .o_conv_start(cs), .o_chan_gain(cg), .o_acq_active(act));
  sacq_conv_model sacq_conv_model_inst (.i_clock(i_clock), .i_start(cs), .i_chan(cg), .i_slow(slow),
    .o_busy(busy), .o_done(done), .o_data(cdata));

  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  always begin
    repeat (6) @(posedge i_clock);
    src5 <= ~src5;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cs === 1'b1) begin
      chq.push_back(cg);
      tq.push_back(cyc);
      if (!slow) nk <= nk + 1;
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [31:0] edat(input int k, input logic [7:0] c);
    return {16'h0, 8'ha5 ^ k[7:0], c};
  endfunction : edat

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    bre <= 1;
    do begin
      @(posedge i_clock);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
    end while (!bv);
    bre <= 0;
    wrr = br;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge i_clock);
    arv <= 1;
    ara <= a;
    rre <= 1;
    do begin
      @(posedge i_clock);
      if (arv && arr) arv <= 0;
    end while (!rv);
    rre <= 0;
    rdv = rdat;
    rr = rresp;
  endtask : rdr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    rdr(a);
    cmp(rdv & m, e);
  endtask : rc
  task automatic ld(input int n);
    for (int i = 0; i < n; i++) begin
      lfsr = nxt(lfsr);
      ent[i] = lfsr[7:0];
      wr(OFS_POS, 32'(i));
      wr(OFS_ENTRY, {23'h0, i == n - 1, ent[i]});
    end
  endtask : ld
  task automatic acq(input logic [2:0] c1, input int cnt, input bit hw, input bit tp);
    wr(OFS_CLEAR, 0);
    wr(OFS_POS, 0);
    wr(OFS_SC_LOAD, 32'(cnt));
    wr(OFS_CMD1, {29'h0, c1});
    chq.delete();
    tq.delete();
    k0 = nk;
    if (hw) begin
      trg_n <= 0;
      repeat (3) @(posedge i_clock);
      trg_n <= 1;
    end else begin
      wr(OFS_START, 0);
    end
    if (tp) begin
      while (chq.size() < 2) @(posedge i_clock);
      repeat (10) @(posedge i_clock);
      t1_n <= 0;
      repeat (4) @(posedge i_clock);
      t1_n <= 1;
    end
    wait (act === 1'b1);
    wait (act === 1'b0);
    repeat (30) @(posedge i_clock);
  endtask : acq
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (95000) @(posedge i_clock);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_nrst <= 1;
    wait (awr === 1'b1);
    rc(OFS_CMD1, 0);
    rc(OFS_MODE, {16'h0, MODE_RST});
    rc(OFS_SI_LOAD, {16'h0, LOAD_RST});
    rc(OFS_STATUS, 0);
    rdr(8'h30);
    cmp(32'(rr), 32'(RESP_SLVERR));
    wr(8'h30, 0);
    cmp(32'(wrr), 32'(RESP_SLVERR));
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      wr(OFS_SCAN_LOAD, {16'h0, lfsr[15:0]});
      cmp(32'(wrr), 32'(RESP_OKAY));
      rc(OFS_SCAN_LOAD, {16'h0, lfsr[15:0]});
    end
    wr(OFS_CMD1, 32'h2);
    wr(OFS_START, 0);
    repeat (8) @(posedge i_clock);
    cmp(32'(act), 0);
    wr(OFS_CMD1, 32'h1);
    wr(OFS_START, 32'h5);
    repeat (8) @(posedge i_clock);
    cmp(32'(act), 0);
    ld(3);
    acq(3, 7, 0, 0);
    cmp(32'(tq.size()), 7);
    cmp(32'(tq[1] - tq[0]), 2 * PRE_DIV);
    for (int i = 0; i < 7; i++) cmp(32'(chq[i]), 32'(ent[i % 3]));
    rc(OFS_STATUS, 32'h2000, 32'h2000);
    for (int i = 0; i < 7; i++) rc(OFS_RESULT, edat(k0 + i, chq[i]));
    rc(OFS_STATUS, 0, 32'h2000);
    acq(1, 3, 1, 0);
    cmp(32'(tq.size()), 3);
    for (int i = 0; i < 3; i++) cmp(32'(chq[i]), 32'(ent[0]));
    acq(7, 4, 0, 1);
    for (int i = 0; i < 4; i++) cmp(32'(chq[i]), 32'(ent[i / 2]));
    wr(OFS_CMD2, 1);
    wr(OFS_SCAN_LOAD, 32'ha);
    acq(3, 6, 0, 0);
    cmp(32'(tq[3] - tq[2] > 120), 1);
    cmp(32'(chq[3]), 32'(ent[0]));
    wr(OFS_CMD2, 0);
    wr(OFS_MODE, {16'h0, MODE_100KHZ});
    acq(1, 2, 0, 0);
    cmp(32'(tq[1] - tq[0]), 20 * PRE_DIV);
    wr(OFS_MODE, {16'h0, MODE_10KHZ});
    acq(1, 2, 0, 0);
    cmp(32'(tq[1] - tq[0]), 200 * PRE_DIV);
    wr(OFS_MODE, {16'h0, MODE_SRC5});
    acq(1, 2, 0, 0);
    cmp(32'(tq[1] - tq[0]), 24);
    wr(OFS_MODE, {16'h0, MODE_1MHZ});
    acq(1, 520, 0, 0);
    rc(OFS_STATUS, 32'h1000, 32'h1c00);
    cmp(32'(tq.size() < 520), 1);
    rc(OFS_RESULT, edat(k0, ent[0]));
    slow <= 1;
    acq(3, 5, 0, 0);
    rc(OFS_STATUS, 32'h0800, 32'h1c00);
    cmp(32'(tq.size() < 5), 1);
    lfsr = nxt(lfsr);
    wr(OFS_CLEAR, lfsr);
    rc(OFS_STATUS, 0, 32'h1800);
    conclude();
  end
endmodule : sacq_top_tb

bind sacq_top sacq_properties sacq_properties_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .i_rready(i_rready), .i_conv_busy(i_conv_busy), .o_conv_start(o_conv_start), .o_acq_active(o_acq_active));
